// >>> core/roic_pkg.sv
// Constants shared by the relay output and input conditioning unit.
// Assumes one 200 MHz clock and a 32-bit word-per-register bus with byte offsets.
package roic_pkg;
  localparam int NUM_TRIP = 13;
  localparam int NUM_DI = 12;
  localparam int NUM_LOGIC = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DELAY_W = 13;
  localparam int COUNT_W = 16;
  localparam int FTMR_W = 15;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FORCE_TIMEOUT_MIN = 5;
  localparam logic [FTMR_W-1:0] FORCE_TICKS = FTMR_W'(FORCE_TIMEOUT_MIN * 60 * 1000 / TICK_MS);
  localparam logic [DELAY_W-1:0] DELAY_MAX = DELAY_W'(60 * 1000 / TICK_MS);
  localparam logic [1:0] AC_HOLD_TICKS = 2'h2;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] FORCE_TRIP_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] FORCE_MISC_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] OUT_STATE_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] DI_POLARITY_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] DI_ON_EVT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] DI_OFF_EVT_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] DI_ALARM_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] DI_STATE_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h2c;
  localparam logic [ADDR_W-1:0] LOGIC_SRC_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] DI_DELAY_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] DI_COUNT_BASE = 8'h80;

  // Field positions
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_AC_BIT = 1;
  localparam int MISC_ALARM_BIT = 0;
  localparam int MISC_SERVICE_BIT = 1;
  localparam int OUT_ALARM_BIT = 16;
  localparam int OUT_SERVICE_BIT = 17;
  localparam int OUT_FORCE_BIT = 18;
  localparam int IRQ_ON_LSB = 0;
  localparam int IRQ_OFF_LSB = 12;
  localparam int IRQ_TIMEOUT_BIT = 24;
  localparam int IRQ_W = 25;
  localparam int SLOT_LSB = 16;

  // Reset values
  localparam logic [NUM_DI-1:0] DI_CFG_RESET = 12'h000;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 13'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  // Card slot layout of the inputs
  localparam int FIRST_SLOT = 2;
  localparam int DI_PER_CARD = 6;

  function automatic logic [2:0] roic_di_slot(input int idx);
    roic_di_slot = 3'(FIRST_SLOT + idx / DI_PER_CARD);
  endfunction
endpackage

// >>> core/roic_tick_div.sv
// Divider that turns the system clock into a one-cycle tick pulse.
// Assumes a free-running mclk; the period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
module roic_tick_div #(
  parameter int CYCLES = 2000000
) (
  input wire logic mclk,
  input wire logic reset_n,
  output logic tick
);
  import roic_pkg::*;

  logic [21:0] count;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 22'h000000;
      tick <= 1'b0;
    end else if (count >= 22'(CYCLES - 1)) begin
      count <= 22'h000000;
      tick <= 1'b1;
    end else begin
      count <= count + 22'h000001;
      tick <= 1'b0;
    end
  end
endmodule

// >>> core/roic_input_cond.sv
// Conditioning of one discrete input: polarity, AC ride-through, on/off delay.
// Assumes raw is already synchronous to mclk and tick is a 10 ms pulse.
`timescale 1ns/1ps
module roic_input_cond (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic raw,
  input wire logic nc_polarity,
  input wire logic ac_mode,
  input wire logic [roic_pkg::DELAY_W-1:0] delay,
  output logic state,
  output logic active_edge,
  output logic inactive_edge
);
  import roic_pkg::*;

  logic level;
  logic bridged;
  logic [1:0] hold;
  logic [DELAY_W-1:0] elapsed;

  // Inverting for NC makes the active edge always a rise of level
  assign level = raw ^ nc_polarity;

  // AC inputs drop at each zero crossing, so a short low is bridged
  assign bridged = level | (ac_mode & (hold != 2'h0));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 2'h0;
    end else if (level) begin
      hold <= AC_HOLD_TICKS;
    end else if (tick && hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end

  // One delay for both directions; a bounce restarts the wait
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      elapsed <= DELAY_RESET;
      state <= 1'b0;
      active_edge <= 1'b0;
      inactive_edge <= 1'b0;
    end else begin
      active_edge <= 1'b0;
      inactive_edge <= 1'b0;
      if (bridged == state) begin
        elapsed <= DELAY_RESET;
      end else if (elapsed >= delay) begin
        elapsed <= DELAY_RESET;
        state <= bridged;
        active_edge <= bridged;
        inactive_edge <= ~bridged;
      end else if (tick) begin
        elapsed <= elapsed + 13'h0001;
      end
    end
  end
endmodule

// >>> core/roic_top.sv
// Relay output holding with common test forcing, and discrete input conditioning.
// Assumes a plain register port with read data one cycle after the read strobe,
// and a password session level supplied by the surrounding controller.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module roic_top #(
  parameter int TICK_CYCLES = roic_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [roic_pkg::ADDR_W-1:0] addr,
  input wire logic [roic_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [roic_pkg::DATA_W-1:0] rdata,
  input wire logic password_valid,
  input wire logic [roic_pkg::NUM_TRIP-1:0] trip_control,
  input wire logic alarm_control,
  input wire logic service_control,
  output logic [roic_pkg::NUM_TRIP-1:0] trip_output_n,
  output logic alarm_output,
  output logic service_status_output,
  output logic stage_force_active,
  input wire logic [roic_pkg::NUM_DI-1:0] discrete_input_n,
  output logic [roic_pkg::NUM_DI-1:0] di_state,
  output logic ac_mode,
  output logic [roic_pkg::NUM_DI-1:0] on_event,
  output logic [roic_pkg::NUM_DI-1:0] off_event,
  output logic [roic_pkg::NUM_DI-1:0] alarm_popup,
  input wire logic [roic_pkg::NUM_LOGIC-1:0] logic_built,
  input wire logic [roic_pkg::NUM_LOGIC-1:0] logic_out,
  output logic [roic_pkg::NUM_LOGIC-1:0] matrix_logic_source,
  output logic irq
);
  import roic_pkg::*;

  logic tick;
  logic force_on;
  logic [FTMR_W-1:0] force_timer;
  logic force_expire;
  logic [NUM_TRIP-1:0] forced_trip;
  logic forced_alarm;
  logic forced_service;
  logic [NUM_DI-1:0] nc_polarity;
  logic [NUM_DI-1:0] on_evt_en;
  logic [NUM_DI-1:0] off_evt_en;
  logic [NUM_DI-1:0] alarm_en;
  logic [DELAY_W-1:0] di_delay [NUM_DI];
  logic [COUNT_W-1:0] di_count [NUM_DI];
  logic [NUM_DI-1:0] act_edge;
  logic [NUM_DI-1:0] inact_edge;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_set;
  logic [NUM_LOGIC-1:0] logic_src;
  logic [NUM_LOGIC-1:0] logic_built_d;
  logic [DATA_W-1:0] next_rdata;
  logic set_ok;

  function automatic logic wr_at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    wr_at = (a == ofs);
  endfunction

  // Index into a per-input block, or NUM_DI when outside it
  function automatic int di_index(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    int idx;
    idx = NUM_DI;
    if (a[ADDR_W-1:6] == base[ADDR_W-1:6] && a[1:0] == 2'h0 && int'(a[5:2]) < NUM_DI) begin
      idx = int'(a[5:2]);
    end
    di_index = idx;
  endfunction

  assign set_ok = wr & password_valid;

  roic_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // Force flag and its timeout

  assign force_expire = force_on & tick & (force_timer >= FORCE_TICKS - 15'h0001);

  // Hardware clear beats a software set in the same cycle so the timeout always ends a session
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      force_on <= 1'b0;
    end else if (force_expire) begin
      force_on <= 1'b0;
    end else if (set_ok && wr_at(addr, CTRL_OFS)) begin
      force_on <= wdata[CTRL_FORCE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      force_timer <= 15'h0000;
    end else if (!force_on || force_expire) begin
      force_timer <= 15'h0000;
    end else if (tick) begin
      force_timer <= force_timer + 15'h0001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ac_mode <= 1'b0;
    end else if (set_ok && wr_at(addr, CTRL_OFS)) begin
      ac_mode <= wdata[CTRL_AC_BIT];
    end
  end

  // Forced output values; dropped whenever forcing ends
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      forced_trip <= '0;
      forced_alarm <= 1'b0;
      forced_service <= 1'b0;
    end else if (!force_on || force_expire) begin
      forced_trip <= '0;
      forced_alarm <= 1'b0;
      forced_service <= 1'b0;
    end else if (wr && wr_at(addr, FORCE_TRIP_OFS)) begin
      forced_trip <= wdata[NUM_TRIP-1:0];
    end else if (wr && wr_at(addr, FORCE_MISC_OFS)) begin
      forced_alarm <= wdata[MISC_ALARM_BIT];
      forced_service <= wdata[MISC_SERVICE_BIT];
    end
  end

  // Outputs are registered so a forced value and the routed one never glitch together
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trip_output_n <= '0;
      alarm_output <= 1'b0;
      service_status_output <= 1'b0;
      stage_force_active <= 1'b0;
    end else begin
      trip_output_n <= force_on ? forced_trip : trip_control;
      alarm_output <= force_on ? forced_alarm : alarm_control;
      service_status_output <= force_on ? forced_service : service_control;
      stage_force_active <= force_on;
    end
  end

  // Input configuration

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nc_polarity <= DI_CFG_RESET;
      on_evt_en <= DI_CFG_RESET;
      off_evt_en <= DI_CFG_RESET;
      alarm_en <= DI_CFG_RESET;
    end else if (set_ok) begin
      if (wr_at(addr, DI_POLARITY_OFS)) begin
        nc_polarity <= wdata[NUM_DI-1:0];
      end
      if (wr_at(addr, DI_ON_EVT_OFS)) begin
        on_evt_en <= wdata[NUM_DI-1:0];
      end
      if (wr_at(addr, DI_OFF_EVT_OFS)) begin
        off_evt_en <= wdata[NUM_DI-1:0];
      end
      if (wr_at(addr, DI_ALARM_OFS)) begin
        alarm_en <= wdata[NUM_DI-1:0];
      end
    end
  end

  for (genvar i = 0; i < NUM_DI; i++) begin : g_di
    // Values above 60 s are clamped rather than refused
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        di_delay[i] <= DELAY_RESET;
      end else if (set_ok && di_index(addr, DI_DELAY_BASE) == i) begin
        di_delay[i] <= (wdata[DELAY_W-1:0] > DELAY_MAX) ? DELAY_MAX : wdata[DELAY_W-1:0];
      end
    end

    roic_input_cond u_cond (
      .mclk(mclk),
      .reset_n(reset_n),
      .tick(tick),
      .raw(discrete_input_n[i]),
      .nc_polarity(nc_polarity[i]),
      .ac_mode(ac_mode),
      .delay(di_delay[i]),
      .state(di_state[i]),
      .active_edge(act_edge[i]),
      .inactive_edge(inact_edge[i])
    );

    // Wraps from 65535 back to 0; a preset in the same cycle as an edge wins
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        di_count[i] <= COUNT_RESET;
      end else if (set_ok && di_index(addr, DI_COUNT_BASE) == i) begin
        di_count[i] <= wdata[COUNT_W-1:0];
      end else if (act_edge[i]) begin
        di_count[i] <= di_count[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      on_event <= '0;
      off_event <= '0;
      alarm_popup <= '0;
    end else begin
      on_event <= act_edge & on_evt_en;
      off_event <= inact_edge & off_evt_en;
      alarm_popup <= act_edge & alarm_en;
    end
  end

  // Logic outputs join the matrix source list once built

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      logic_built_d <= '0;
      logic_src <= '0;
    end else begin
      logic_built_d <= logic_built;
      logic_src <= logic_src | (logic_built & ~logic_built_d);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      matrix_logic_source <= '0;
    end else begin
      matrix_logic_source <= logic_out & logic_src;
    end
  end

  // Interrupts: a new event wins over a clear in the same cycle

  assign irq_set = {force_expire, inact_edge & off_evt_en, act_edge & on_evt_en};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= '0;
    end else if (wr && wr_at(addr, IRQ_CLEAR_OFS)) begin
      irq_status <= (irq_status & ~wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable <= '0;
    end else if (wr && wr_at(addr, IRQ_ENABLE_OFS)) begin
      irq_enable <= wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // Read path

  always_comb begin
    int di;
    int ci;
    di = di_index(addr, DI_DELAY_BASE);
    ci = di_index(addr, DI_COUNT_BASE);
    next_rdata = '0;
    unique case (addr)
      CTRL_OFS: begin
        next_rdata[CTRL_FORCE_BIT] = force_on;
        next_rdata[CTRL_AC_BIT] = ac_mode;
      end
      FORCE_TRIP_OFS: next_rdata[NUM_TRIP-1:0] = forced_trip;
      FORCE_MISC_OFS: begin
        next_rdata[MISC_ALARM_BIT] = forced_alarm;
        next_rdata[MISC_SERVICE_BIT] = forced_service;
      end
      OUT_STATE_OFS: begin
        next_rdata[NUM_TRIP-1:0] = trip_output_n;
        next_rdata[OUT_ALARM_BIT] = alarm_output;
        next_rdata[OUT_SERVICE_BIT] = service_status_output;
        next_rdata[OUT_FORCE_BIT] = force_on;
      end
      DI_POLARITY_OFS: next_rdata[NUM_DI-1:0] = nc_polarity;
      DI_ON_EVT_OFS: next_rdata[NUM_DI-1:0] = on_evt_en;
      DI_OFF_EVT_OFS: next_rdata[NUM_DI-1:0] = off_evt_en;
      DI_ALARM_OFS: next_rdata[NUM_DI-1:0] = alarm_en;
      DI_STATE_OFS: next_rdata[NUM_DI-1:0] = di_state;
      IRQ_STATUS_OFS: next_rdata[IRQ_W-1:0] = irq_status;
      IRQ_ENABLE_OFS: next_rdata[IRQ_W-1:0] = irq_enable;
      LOGIC_SRC_OFS: next_rdata[NUM_LOGIC-1:0] = logic_src;
      default: begin
        for (int k = 0; k < NUM_DI; k++) begin
          if (di == k) begin
            next_rdata[DELAY_W-1:0] = di_delay[k];
            next_rdata[SLOT_LSB+2:SLOT_LSB] = roic_di_slot(k);
          end
          if (ci == k) begin
            next_rdata[COUNT_W-1:0] = di_count[k];
          end
        end
      end
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? next_rdata : '0;
    end
  end
endmodule

// >>> testbench/roic_field_model.sv
// Field contact model: commanded contact closure becomes the raw input level.
// Assumes a closed contact energizes its input; changes land on mclk edges.
`timescale 1ns/1ps
module roic_field_model (
  input wire logic mclk,
  input wire logic [roic_pkg::NUM_DI-1:0] closed,
  output logic [roic_pkg::NUM_DI-1:0] contact
);
  initial contact = '0;
  // Sampling on mclk keeps the raw level synchronous, as the design expects
  always @(posedge mclk) begin
    contact <= closed;
  end
endmodule

// >>> testbench/roic_top_monitor.sv
// Checker for the relay output and input conditioning top module.
// Sees only the top module's ports; bound from the bench top file.
`timescale 1ns/1ps
module roic_top_monitor #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wr,
  input wire logic rd,
  input wire logic [roic_pkg::DATA_W-1:0] rdata,
  input wire logic [roic_pkg::NUM_TRIP-1:0] trip_control,
  input wire logic alarm_control,
  input wire logic service_control,
  input wire logic [roic_pkg::NUM_TRIP-1:0] trip_output_n,
  input wire logic alarm_output,
  input wire logic service_status_output,
  input wire logic stage_force_active,
  input wire logic [roic_pkg::NUM_DI-1:0] di_state,
  input wire logic [roic_pkg::NUM_DI-1:0] on_event,
  input wire logic [roic_pkg::NUM_DI-1:0] off_event,
  input wire logic [roic_pkg::NUM_DI-1:0] alarm_popup,
  input wire logic [roic_pkg::NUM_LOGIC-1:0] logic_out,
  input wire logic [roic_pkg::NUM_LOGIC-1:0] matrix_logic_source
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Outputs only start following their controls one edge after reset has been released
  sequence s_free;
    $past(reset_n) && !$past(stage_force_active) && !stage_force_active;
  endsequence
  // Three forced cycles with no write: the forced values must hold still
  sequence s_quiet_force;
    (stage_force_active && !wr) [*3];
  endsequence
  property p_rd_idle;
    !$past(rd) |-> rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero outside read");
  property p_trip_free;
    s_free |-> trip_output_n == $past(trip_control);
  endproperty
  a_trip_free: assert property (p_trip_free) else $error("trip not following control");
  property p_alarm_free;
    s_free |-> alarm_output == $past(alarm_control);
  endproperty
  a_alarm_free: assert property (p_alarm_free) else $error("alarm not following");
  property p_service_free;
    s_free |-> service_status_output == $past(service_control);
  endproperty
  a_service_free: assert property (p_service_free) else $error("service not following");
  property p_forced_hold;
    s_quiet_force |-> $stable({trip_output_n, alarm_output, service_status_output});
  endproperty
  a_forced_hold: assert property (p_forced_hold) else $error("forced output moved");
  property p_on_cause;
    (on_event & ~($past(di_state) & ~$past(di_state, 2))) == '0;
  endproperty
  a_on_cause: assert property (p_on_cause) else $error("on event without active edge");
  property p_off_cause;
    (off_event & ~(~$past(di_state) & $past(di_state, 2))) == '0;
  endproperty
  a_off_cause: assert property (p_off_cause) else $error("off event without edge");
  property p_popup_cause;
    (alarm_popup & ~($past(di_state) & ~$past(di_state, 2))) == '0;
  endproperty
  a_popup_cause: assert property (p_popup_cause) else $error("popup without edge");
  property p_on_single;
    |on_event |=> (on_event & $past(on_event)) == '0;
  endproperty
  a_on_single: assert property (p_on_single) else $error("on event longer than one cycle");
  property p_matrix;
    (matrix_logic_source & ~$past(logic_out)) == '0;
  endproperty
  a_matrix: assert property (p_matrix) else $error("matrix source without logic output");
endmodule

// >>> testbench/roic_top_bench.sv
// Self-checking bench for the relay output and input conditioning unit.
// Runs the design with a 2-cycle tick so the force timeout fits the run.
`timescale 1ns/1ps
module roic_top_bench;
  import roic_pkg::*;
  localparam int TC = 2;
  logic mclk, reset_n, wr, rd, password_valid, alarm_control, service_control;
  logic alarm_output, service_status_output, stage_force_active, ac_mode, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [NUM_TRIP-1:0] trip_control, trip_output_n;
  logic [NUM_DI-1:0] discrete_input_n, closed, di_state, on_event, off_event, alarm_popup;
  logic [NUM_LOGIC-1:0] logic_built, logic_out, matrix_logic_source;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  roic_top #(.TICK_CYCLES(TC)) uut (.mclk(mclk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .password_valid(password_valid),
    .trip_control(trip_control), .alarm_control(alarm_control),
    .service_control(service_control), .trip_output_n(trip_output_n),
    .alarm_output(alarm_output), .service_status_output(service_status_output),
    .stage_force_active(stage_force_active), .discrete_input_n(discrete_input_n),
    .di_state(di_state), .ac_mode(ac_mode), .on_event(on_event), .off_event(off_event),
    .alarm_popup(alarm_popup), .logic_built(logic_built), .logic_out(logic_out),
    .matrix_logic_source(matrix_logic_source), .irq(irq));
  roic_field_model field (.mclk(mclk), .closed(closed), .contact(discrete_input_n));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Sets a contact, then waits for the filtered state s and checks it
  task automatic toggle(input int b, input logic v, input logic s);
    @(posedge mclk);
    closed[b] <= v;
    #1 n = 0;
    while (di_state[b] !== s && n < 300) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(di_state[b], s);
  endtask
  task automatic tick2();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    password_valid = 1'b0;
    trip_control = 13'h1555;
    alarm_control = 1'b1;
    service_control = 1'b0;
    closed = '0;
    logic_built = '0;
    logic_out = 4'ha;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rchk(CTRL_OFS, 32'h0);
    rchk(DI_DELAY_BASE, 32'h0002_0000);
    rchk(DI_DELAY_BASE + 8'h2c, 32'h0003_0000);
    rchk(8'hfc, 32'h0);
    wreg(CTRL_OFS, 32'h1);
    wreg(DI_POLARITY_OFS, 32'hfff);
    wreg(FORCE_TRIP_OFS, 32'h0aaa);
    rchk(CTRL_OFS, 32'h0);
    rchk(DI_POLARITY_OFS, 32'h0);
    rchk(OUT_STATE_OFS, 32'h0001_1555);
    $display("test refusals done");
    @(posedge mclk) password_valid <= 1'b1;
    wreg(CTRL_OFS, 32'h1);
    wreg(FORCE_TRIP_OFS, 32'h0f0f);
    wreg(FORCE_MISC_OFS, 32'h2);
    tick2();
    chk({trip_output_n, alarm_output, service_status_output, stage_force_active},
      {13'h0f0f, 3'b011});
    n = 0;
    while (stage_force_active === 1'b1 && n < 61000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n >= 59900 && n <= 60010, 1'b1);
    tick2();
    chk({trip_output_n, alarm_output, service_status_output}, {13'h1555, 2'b10});
    rchk(IRQ_STATUS_OFS, 32'h0100_0000);
    chk(irq, 1'b0);
    wreg(IRQ_ENABLE_OFS, 32'h0100_0000);
    tick2();
    chk(irq, 1'b1);
    wreg(IRQ_CLEAR_OFS, 32'h0100_0000);
    tick2();
    chk(irq, 1'b0);
    wreg(CTRL_OFS, 32'h1);
    tick2();
    chk(trip_output_n, 13'h0);
    wreg(CTRL_OFS, 32'h0);
    $display("test force done");
    wreg(DI_ON_EVT_OFS, 32'hffb);
    wreg(DI_OFF_EVT_OFS, 32'hfff);
    wreg(DI_ALARM_OFS, 32'h1);
    toggle(0, 1'b1, 1'b1);
    @(posedge mclk);
    #1 chk({on_event, alarm_popup}, {12'h001, 12'h001});
    toggle(0, 1'b0, 1'b0);
    @(posedge mclk);
    #1 chk({off_event, alarm_popup}, {12'h001, 12'h000});
    rchk(DI_COUNT_BASE, 32'h1);
    wreg(DI_COUNT_BASE, 32'hffff);
    toggle(0, 1'b1, 1'b1);
    toggle(0, 1'b0, 1'b0);
    rchk(DI_COUNT_BASE, 32'h0);
    wreg(DI_POLARITY_OFS, 32'h2);
    toggle(1, 1'b1, 1'b0);
    toggle(1, 1'b0, 1'b1);
    rchk(DI_COUNT_BASE + 8'h04, 32'h2);
    rchk(IRQ_STATUS_OFS, 32'h0000_3003);
    $display("test edges done");
    wreg(DI_DELAY_BASE + 8'h08, 32'h5);
    @(posedge mclk) closed[2] <= 1'b1;
    repeat (4) @(posedge mclk);
    closed[2] <= 1'b0;
    repeat (20) @(posedge mclk);
    #1 chk(di_state[2], 1'b0);
    toggle(2, 1'b1, 1'b1);
    chk(n >= 5 * TC - 2 && n <= 5 * TC + 4, 1'b1);
    @(posedge mclk);
    #1 chk(on_event, 12'h0);
    wreg(DI_DELAY_BASE + 8'h08, 32'h1fff);
    rchk(DI_DELAY_BASE + 8'h08, 32'h0002_1770);
    $display("test delay done");
    wreg(CTRL_OFS, 32'h2);
    rchk(CTRL_OFS, 32'h2);
    chk(ac_mode, 1'b1);
    toggle(3, 1'b1, 1'b1);
    @(posedge mclk) closed[3] <= 1'b0;
    @(posedge mclk) closed[3] <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(di_state[3], 1'b1);
    rchk(DI_COUNT_BASE + 8'h0c, 32'h1);
    $display("test ac done");
    @(posedge mclk) logic_built <= 4'h2;
    repeat (4) @(posedge mclk);
    #1 chk(matrix_logic_source, 4'h2);
    rchk(LOGIC_SRC_OFS, 32'h2);
    @(posedge mclk) {trip_control, alarm_control, service_control} <= {13'h0aaa, 2'b01};
    rchk(OUT_STATE_OFS, 32'h0002_0aaa);
    $display("test logic done");
    summarize();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    summarize();
  end
endmodule
bind roic_top roic_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.mclk(mclk),
  .reset_n(reset_n), .wr(wr), .rd(rd), .rdata(rdata), .trip_control(trip_control),
  .alarm_control(alarm_control), .service_control(service_control),
  .trip_output_n(trip_output_n), .alarm_output(alarm_output),
  .service_status_output(service_status_output), .stage_force_active(stage_force_active),
  .di_state(di_state), .on_event(on_event), .off_event(off_event),
  .alarm_popup(alarm_popup), .logic_out(logic_out), .matrix_logic_source(matrix_logic_source));
